// file: hdl/wwd_feed_seq.sv
// Purpose: Recognises the two-word feed sequence.
// Assumes: acc_i pulses once per accepted register access.
// Notes: Any other access between the two words breaks the sequence.
`timescale 1ns/1ps
`default_nettype none
module wwd_feed_seq (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic acc_i,
	input wire logic feed_wr_i,
	input wire logic [7:0] data_i,
	output logic feed_o,
	output logic error_o
);
	typedef enum logic {WWD_IDLE, WWD_ARMED} wwd_feed_t;
	wwd_feed_t state_reg;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_reg <= WWD_IDLE;
			feed_o <= 1'b0;
			error_o <= 1'b0;
		end else begin
			feed_o <= 1'b0;
			error_o <= 1'b0;
			if (acc_i) begin
				unique case (state_reg)
					WWD_IDLE: begin
						if (feed_wr_i && data_i == wwd_pkg::FEED_FIRST) begin
							state_reg <= WWD_ARMED; // [R15]
						end else if (feed_wr_i) begin
							error_o <= 1'b1; // [R18]
						end
					end
					WWD_ARMED: begin
						state_reg <= WWD_IDLE;
						if (feed_wr_i && data_i == wwd_pkg::FEED_SECOND) begin
							feed_o <= 1'b1; // [R15]
						end else begin
							error_o <= 1'b1; // [R18]
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/wwd_tick_div.sv
// Purpose: Watchdog tick clock enable derived from the system clock.
// Assumes: Divider value is held steady by software.
// Notes: Tick pulses once every div_i+1 clocks.
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_div (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [15:0] div_i,
	output logic tick_o
);
	logic [15:0] cnt_reg;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt_reg <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt_reg >= div_i) begin
			cnt_reg <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: hdl/wwd_top.sv
// Purpose: Windowed watchdog timer with Avalon-MM register slave.
// Assumes: Single clock; tick clock is an enable from a divider.
// Notes: Counter steps once every four ticks.
// Notes on behaviour
// [R1] Enable set plus feed runs counter permanently
// [R2] Writing zero to enable has no effect
// [R3] Warning raised one tick after compare
// [R4] Each feed reloads counter from reload value
// [R5] Reload writes below 0xFF store 0xFF
// [R6] Counter decrements every four ticks
// [R7] Protected early reload write causes reset
// [R8] Feed above window value is watchdog event
// [R9] Counter 24 bits; all-ones window disables
// [R10] Software feeds before timeout, else reset
// [R11] Timeout flag set on counter expiry
// [R12] Warning flag set below warning value
// [R13] Reset-on-timeout chooses reset or flag only
// [R14] Oscillator lock blocks power-down until reset
// [R15] Feed is two fixed words in order
// [R16] Flags cleared individually by selecting write
// [R17] Warning value zero gives no warning
// [R18] Feed words 0xAA then 0x55, else error
// [R19] Write one clears flag, zero keeps
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wwd_top (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	output logic chip_reset_o,
	output logic osc_lock_o
);
	localparam int W = wwd_pkg::CNT_W;

	logic [3:0] mode_reg;
	logic [W-1:0] reload_reg;
	logic [W-1:0] counter_reg;
	logic [W-1:0] warn_reg;
	logic [W-1:0] window_reg;
	logic [2:0] status_reg;
	logic [2:0] mask_reg;
	logic [15:0] tickdiv_reg;
	logic [1:0] presc_reg;
	logic running_reg;
	logic warn_seen_reg;
	logic ack_reg;
	logic tick;
	logic feed;
	logic feed_err;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] byte_addr;
	logic step;
	logic expire;
	logic win_violation;
	logic prot_violation;
	logic wd_event;
	logic warn_set;
	logic [W-1:0] reload_next;

	// One wait state per access: request seen, then acknowledged next edge
	assign wr_acc = avs_write_i && ack_reg;
	assign rd_acc = avs_read_i && ack_reg;
	assign byte_addr = {avs_address_i, 2'b00};

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
		end
	end

	always_comb begin
		avs_waitrequest_o = !ack_reg;
	end

	wwd_tick_div u_div (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.div_i(tickdiv_reg),
		.tick_o(tick)
	);

	wwd_feed_seq u_feed (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.acc_i(wr_acc || rd_acc),
		.feed_wr_i(wr_acc && byte_addr == wwd_pkg::OFS_FEED),
		.data_i(avs_writedata_i[7:0]),
		.feed_o(feed),
		.error_o(feed_err)
	);

	assign step = running_reg && tick && presc_reg == wwd_pkg::PRESCALE_LAST; // [R6]
	assign expire = step && counter_reg == '0; // [R11]
	assign win_violation = feed && running_reg && counter_reg > window_reg; // [R8] [R9]
	assign prot_violation = wr_acc && byte_addr == wwd_pkg::OFS_RELOAD
		&& mode_reg[wwd_pkg::MODE_PROT]
		&& !(counter_reg < warn_reg && counter_reg < window_reg); // [R7]
	assign wd_event = expire || win_violation || prot_violation || feed_err;

	always_comb begin
		reload_next = avs_writedata_i[W-1:0];
		if (reload_next < wwd_pkg::RELOAD_MIN) begin
			reload_next = wwd_pkg::RELOAD_MIN; // [R5]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mode_reg <= 4'h0;
			reload_reg <= wwd_pkg::RELOAD_RST;
			warn_reg <= wwd_pkg::WARN_RST;
			window_reg <= wwd_pkg::WINDOW_RST;
			mask_reg <= 3'h0;
			tickdiv_reg <= wwd_pkg::TICKDIV_RST;
		end else if (wr_acc) begin
			unique case (byte_addr)
				wwd_pkg::OFS_MODE: begin
					// Enable and lock are sticky; only reset clears them
					mode_reg[wwd_pkg::MODE_EN] <= mode_reg[wwd_pkg::MODE_EN]
						| avs_writedata_i[wwd_pkg::MODE_EN]; // [R1] [R2]
					mode_reg[wwd_pkg::MODE_LOCK] <= mode_reg[wwd_pkg::MODE_LOCK]
						| avs_writedata_i[wwd_pkg::MODE_LOCK]; // [R14]
					mode_reg[wwd_pkg::MODE_RST] <= avs_writedata_i[wwd_pkg::MODE_RST];
					mode_reg[wwd_pkg::MODE_PROT] <= avs_writedata_i[wwd_pkg::MODE_PROT];
				end
				wwd_pkg::OFS_RELOAD: reload_reg <= reload_next; // [R5]
				wwd_pkg::OFS_WARN: warn_reg <= avs_writedata_i[W-1:0];
				wwd_pkg::OFS_WINDOW: window_reg <= avs_writedata_i[W-1:0];
				wwd_pkg::OFS_MASK: mask_reg <= avs_writedata_i[2:0];
				wwd_pkg::OFS_TICKDIV: tickdiv_reg <= avs_writedata_i[15:0];
				default: begin
				end
			endcase
		end
	end

	// Counter and prescaler
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			counter_reg <= wwd_pkg::RELOAD_RST;
			presc_reg <= 2'h0;
			running_reg <= 1'b0;
		end else begin
			if (feed && mode_reg[wwd_pkg::MODE_EN]) begin
				running_reg <= 1'b1; // [R1]
			end
			if (feed) begin
				counter_reg <= reload_reg; // [R4]
				presc_reg <= 2'h0;
			end else if (running_reg && tick) begin
				presc_reg <= presc_reg + 2'h1; // [R6]
				if (step) begin
					counter_reg <= (counter_reg == '0) ? reload_reg : counter_reg - 1'b1;
				end
			end
		end
	end

	// Warning one tick after counter reaches compare; zero compare disables
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			warn_seen_reg <= 1'b0;
		end else if (feed) begin
			warn_seen_reg <= 1'b0;
		end else if (running_reg && tick && warn_reg != '0 && counter_reg <= warn_reg) begin
			warn_seen_reg <= 1'b1; // [R3] [R17]
		end
	end
	assign warn_set = running_reg && tick && warn_reg != '0
		&& counter_reg <= warn_reg && !warn_seen_reg && !feed; // [R3] [R12] [R17]

	// Sticky status: set wins over write-one-to-clear
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			status_reg <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_acc && byte_addr == wwd_pkg::OFS_STATUS && avs_writedata_i[i]) begin
					status_reg[i] <= 1'b0; // [R16] [R19]
				end
			end
			if (wd_event) begin
				status_reg[wwd_pkg::ST_TIMEOUT] <= 1'b1; // [R7] [R8] [R11]
			end
			if (warn_set) begin
				status_reg[wwd_pkg::ST_WARN] <= 1'b1; // [R12]
			end
			if (feed_err) begin
				status_reg[wwd_pkg::ST_FEEDERR] <= 1'b1; // [R18]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
			chip_reset_o <= 1'b0;
			osc_lock_o <= 1'b0;
		end else begin
			irq_o <= |(status_reg & mask_reg);
			// Chip reset held until this block itself is reset
			if (wd_event && (mode_reg[wwd_pkg::MODE_RST] || prot_violation)) begin
				chip_reset_o <= 1'b1; // [R7] [R10] [R13]
			end
			osc_lock_o <= mode_reg[wwd_pkg::MODE_LOCK]; // [R14]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			avs_readdata_o <= wwd_pkg::UNMAPPED_DATA;
		end else if (avs_read_i && !ack_reg) begin
			unique case (byte_addr)
				wwd_pkg::OFS_MODE: avs_readdata_o <= {28'h0, mode_reg};
				wwd_pkg::OFS_RELOAD: avs_readdata_o <= {8'h00, reload_reg};
				wwd_pkg::OFS_COUNT: avs_readdata_o <= {8'h00, counter_reg};
				wwd_pkg::OFS_WARN: avs_readdata_o <= {8'h00, warn_reg};
				wwd_pkg::OFS_WINDOW: avs_readdata_o <= {8'h00, window_reg};
				wwd_pkg::OFS_STATUS: avs_readdata_o <= {29'h0, status_reg};
				wwd_pkg::OFS_MASK: avs_readdata_o <= {29'h0, mask_reg};
				wwd_pkg::OFS_TICKDIV: avs_readdata_o <= {16'h0000, tickdiv_reg};
				default: avs_readdata_o <= wwd_pkg::UNMAPPED_DATA;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: pkg/wwd_pkg.sv
// Purpose: Constants for the windowed watchdog timer.
// Assumes: 32-bit Avalon-MM register bus, word offsets as byte addresses.
// Notes: Field positions and the reload, warn, window and tick divider reset values live here.
package wwd_pkg;
	localparam int CNT_W = 24;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_RELOAD = 8'h04;
	localparam logic [7:0] OFS_FEED = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_WARN = 8'h10;
	localparam logic [7:0] OFS_WINDOW = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_MASK = 8'h1c;
	localparam logic [7:0] OFS_TICKDIV = 8'h20;
	localparam int MODE_EN = 0;
	localparam int MODE_RST = 1;
	localparam int MODE_PROT = 2;
	localparam int MODE_LOCK = 3;
	localparam int ST_TIMEOUT = 0;
	localparam int ST_WARN = 1;
	localparam int ST_FEEDERR = 2;
	localparam logic [7:0] FEED_FIRST = 8'haa;
	localparam logic [7:0] FEED_SECOND = 8'h55;
	localparam logic [23:0] RELOAD_MIN = 24'h0000ff;
	localparam logic [23:0] RELOAD_RST = 24'hffffff;
	localparam logic [23:0] WINDOW_RST = 24'hffffff;
	localparam logic [23:0] WARN_RST = 24'h000000;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	localparam logic [15:0] TICKDIV_RST = 16'h0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

// file: tb/tb.sv
// Purpose: Self-checking bench for the watchdog top.
// Assumes: Tick divider left at 0, so one tick per clock.
// Notes: Counts are checked in ranges since the prescaler phase is hidden.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, irq_o, chip_reset_o, osc_lock_o;
	logic [31:0] q, c1;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	logic [5:0] ta [6] = '{6'h01, 6'h01, 6'h04, 6'h05, 6'h03, 6'h0c};
	logic [31:0] tw [6] = '{32'h10, 32'h1234, 32'h0, 32'hffffff, 32'h5, 32'h77};
	logic [31:0] te [6] = '{32'hff, 32'h1234, 32'h0, 32'hffffff, 32'hffffff, 32'h0};
	wwd_top wwd_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .chip_reset_o(chip_reset_o),
		.osc_lock_o(osc_lock_o));
	initial forever #20 clk_i = ~clk_i;
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Whole run needs about 1700 cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	// Leading edge keeps a release and the next request out of one time step
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		// Look at waitrequest mid-cycle, then act on the edge that samples it low
		do @(negedge clk_i); while (avs_waitrequest_o !== 1'b0);
		@(posedge clk_i);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task feed;
		bus(1, 6'h02, 32'haa);
		bus(1, 6'h02, 32'h55);
	endtask
	task do_reset;
		rstn_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
	endtask
	initial begin
		do_reset();
		for (int i = 0; i < 6; i++) begin
			bus(1, ta[i], tw[i]);
			bus(0, ta[i], 32'h0);
			chk("table", te[i], q);
		end
		bus(1, 6'h07, 32'h2);
		bus(1, 6'h04, 32'h1200);
		bus(1, 6'h00, 32'h9);
		bus(1, 6'h00, 32'h0);
		bus(0, 6'h00, 32'h0);
		chk("mode", 32'h9, q);
		chk("lock", 1, osc_lock_o);
		feed();
		bus(0, 6'h03, 32'h0);
		c1 = q;
		repeat (400) @(posedge clk_i);
		bus(0, 6'h03, 32'h0);
		chk("first_count", 1, c1 <= 32'h1234 && c1 > 32'h122c);
		chk("step", 1, c1 - q >= 99 && c1 - q <= 102);
		chk("irq", 1, irq_o);
		bus(1, 6'h06, 32'h0);
		bus(0, 6'h06, 32'h0);
		chk("warn_keep", 32'h2, q & 32'h2);
		bus(1, 6'h06, 32'h2);
		bus(0, 6'h06, 32'h0);
		chk("warn_clear", 32'h0, q & 32'h2);
		chk("irq_low", 0, irq_o);
		bus(1, 6'h01, 32'h0);
		feed();
		repeat (1100) @(posedge clk_i);
		bus(0, 6'h06, 32'h0);
		chk("expiry", 32'h1, q & 32'h1);
		chk("no_reset", 0, chip_reset_o);
		bus(1, 6'h06, 32'h7);
		bus(1, 6'h02, 32'haa);
		bus(0, 6'h00, 32'h0);
		bus(1, 6'h02, 32'h55);
		bus(0, 6'h06, 32'h0);
		chk("feed_err", 32'h5, q & 32'h5);
		bus(1, 6'h05, 32'h10);
		bus(1, 6'h00, 32'hb);
		feed();
		repeat (3) @(posedge clk_i);
		chk("window_reset", 1, chip_reset_o);
		do_reset();
		chk("reset_out", 0, chip_reset_o | osc_lock_o);
		bus(1, 6'h00, 32'h4);
		bus(1, 6'h01, 32'h500);
		repeat (3) @(posedge clk_i);
		chk("protect_reset", 1, chip_reset_o);
		final_report();
	end
endmodule
`default_nettype wire

// file: tb/wwd_top_props.sv
// Purpose: Port checks for the watchdog top.
// Assumes: Word addresses 0 mode, 1 reload, 3 count, 7 mask.
// Notes: Registers are seen through completed reads, the mask through completed writes.
`timescale 1ns/1ps
`default_nettype none
module wwd_top_props (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic irq_o,
	input wire logic chip_reset_o,
	input wire logic osc_lock_o
);
	logic en_seen_reg;
	logic [2:0] mask_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Shadow of the mask, so a zero mask can be tied to a quiet interrupt
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			en_seen_reg <= 1'b0;
			mask_reg <= 3'h0;
		end else begin
			if (avs_read_i && !avs_waitrequest_o && avs_address_i == 6'h00 && avs_readdata_o[0])
				en_seen_reg <= 1'b1;
			if (avs_write_i && !avs_waitrequest_o && avs_address_i == 6'h07)
				mask_reg <= avs_writedata_i[2:0];
		end
	end
	sequence req_s;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence rd_s(a);
		avs_read_i && !avs_waitrequest_o && avs_address_i == a;
	endsequence
	wait_one_a: assert property (req_s |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("wait state not one cycle");
	reset_hold_a: assert property (chip_reset_o |=> chip_reset_o)
		else $error("chip reset dropped");
	lock_hold_a: assert property (osc_lock_o |=> osc_lock_o)
		else $error("lock dropped");
	count_width_a: assert property (rd_s(6'h03) |-> avs_readdata_o[31:24] == 8'h00)
		else $error("count wider than 24 bits");
	reload_floor_a: assert property (rd_s(6'h01) |-> avs_readdata_o[23:0] >= 24'h0000ff)
		else $error("reload below floor");
	lock_mirror_a: assert property (rd_s(6'h00) |-> avs_readdata_o[3] == osc_lock_o)
		else $error("lock output differs");
	enable_keep_a: assert property (rd_s(6'h00) ##0 en_seen_reg |-> avs_readdata_o[0])
		else $error("enable cleared");
	mask_quiet_a: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0
		&& $past(mask_reg, 2) == 3'h0 |-> !irq_o)
		else $error("irq with zero mask");
endmodule
bind wwd_top wwd_top_props wwd_top_props_inst (.clk_i(clk_i), .rstn_i(rstn_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .chip_reset_o(chip_reset_o),
	.osc_lock_o(osc_lock_o));
`default_nettype wire
